// file: hw/bscn_map.vh
// Constants for the boundary-scan test port
`ifndef BSCN_MAP_VH
`define BSCN_MAP_VH
// Shared pin positions while the test port owns them
`define BSCN_PIN_TCK   0
`define BSCN_PIN_TMS   1
`define BSCN_PIN_TDI   2
`define BSCN_PIN_TDO   3
`define BSCN_PIN_TRST  4
`define BSCN_GPIO_W    5
// Instruction register
`define BSCN_IR_W      4
`define BSCN_IR_CAP    4'h1
`define BSCN_OP_EXTEST  4'h0
`define BSCN_OP_IDCODE  4'h1
`define BSCN_OP_SAMPLE  4'h2
`define BSCN_OP_PRELOAD 4'h3
`define BSCN_OP_HIGHZ   4'h4
`define BSCN_OP_CLAMP   4'h5
`define BSCN_OP_BYPASS  4'hf
// Identification register width
`define BSCN_ID_W      32
`endif

// file: hw/bscn_sync.v
// Three-flop pin synchroniser with second/third stage agreement filter
`timescale 1ns/1ps
module bscn_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rst,
  // Asynchronous inputs
  input  wire [W-1:0] async_in,
  // Filtered levels
  output reg  [W-1:0] level_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;

  always @(posedge clock) begin
    s1_q <= async_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // A level counts only once the second and third stages agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_filt
      always @(posedge clock) begin
        if (rst) begin
          level_q[i] <= 1'b1;
        end else if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // bscn_sync

// file: hw/bscn_tap.v
// Boundary-scan test access port sharing five general-purpose pins
// How it works
// - Test-select low hands shared pins to the test port and halts operation.
// - GPIO0..4 carry TCK, TMS, TDI, TDO, TRSTn; revert when select high.
// - Implements IDCODE, BYPASS, EXTEST, SAMPLE, PRELOAD, HIGHZ and CLAMP instructions.
// - IDCODE instruction shifts out the fixed identification code on TDO.
// - TDO changes on TCK falling edge; TMS and TDI sampled on rising.
`timescale 1ns/1ps
`include "bscn_map.vh"
module bscn_tap #(
  parameter N = 8,
  // Identification value is arbitrary; bit 0 must stay 1
  parameter [`BSCN_ID_W-1:0] ID_CODE = 32'h0000_0001
) (
  // Clock and reset
  input  wire                    clock,
  input  wire                    rst,
  // Shared pins
  input  wire [`BSCN_GPIO_W-1:0] gpio_in,
  output reg  [`BSCN_GPIO_W-1:0] gpio_out,
  output reg  [`BSCN_GPIO_W-1:0] gpio_oe_n,
  input  wire                    test_select_n,
  // Normal-mode GPIO function
  input  wire [`BSCN_GPIO_W-1:0] core_gpio_out,
  input  wire [`BSCN_GPIO_W-1:0] core_gpio_oe_n,
  output reg  [`BSCN_GPIO_W-1:0] core_gpio_in,
  output reg                     op_halt,
  // Boundary-scanned device pins
  input  wire [N-1:0]            core_dout,
  input  wire [N-1:0]            core_doe_n,
  output reg  [N-1:0]            core_din,
  input  wire [N-1:0]            pad_in,
  output reg  [N-1:0]            pad_out,
  output reg  [N-1:0]            pad_oe_n
);
  localparam [15:0] S_TLR  = 16'h0001;
  localparam [15:0] S_RTI  = 16'h0002;
  localparam [15:0] S_SDR  = 16'h0004;
  localparam [15:0] S_CDR  = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_E1DR = 16'h0020;
  localparam [15:0] S_PDR  = 16'h0040;
  localparam [15:0] S_E2DR = 16'h0080;
  localparam [15:0] S_UDR  = 16'h0100;
  localparam [15:0] S_SIR  = 16'h0200;
  localparam [15:0] S_CIR  = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_E1IR = 16'h1000;
  localparam [15:0] S_PIR  = 16'h2000;
  localparam [15:0] S_E2IR = 16'h4000;
  localparam [15:0] S_UIR  = 16'h8000;

  wire [N+5:0]            lvl;
  reg                     tck_q;
  reg  [15:0]             st_q;
  reg  [15:0]             st_d;
  reg  [`BSCN_IR_W-1:0]   ir_sh_q;
  reg  [`BSCN_IR_W-1:0]   ir_q;
  reg                     byp_q;
  reg  [`BSCN_ID_W-1:0]   id_sh_q;
  reg  [2*N-1:0]          bsr_sh_q;
  reg  [2*N-1:0]          bsr_upd_q;
  reg                     tdo_q;
  reg                     tdo_en_q;

  bscn_sync #(
    .W (N + 6)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({pad_in, test_select_n, gpio_in}),
    .level_q  (lvl)
  );

  wire test_mode = ~lvl[5];
  wire [N-1:0] pad_lvl = lvl[N+5:6];
  wire tck  = lvl[`BSCN_PIN_TCK];
  wire tms  = lvl[`BSCN_PIN_TMS];
  wire tdi  = lvl[`BSCN_PIN_TDI];
  wire rise = test_mode & tck & ~tck_q;
  wire fall = test_mode & ~tck & tck_q;
  // reset without TCK; leaving test mode also resets the port
  wire tap_rst = rst | ~test_mode | ~lvl[`BSCN_PIN_TRST];

  // instruction decode; unknown codes fall back to bypass
  wire op_id    = (ir_q == `BSCN_OP_IDCODE);
  wire op_ext   = (ir_q == `BSCN_OP_EXTEST);
  wire op_bsr   = op_ext | (ir_q == `BSCN_OP_SAMPLE) | (ir_q == `BSCN_OP_PRELOAD);
  wire op_clamp = (ir_q == `BSCN_OP_CLAMP);
  wire op_highz = (ir_q == `BSCN_OP_HIGHZ);

  always @(posedge clock) begin
    if (rst) begin
      // Matches the filter's reset level so no edge is seen after reset
      tck_q <= 1'b1;
    end else begin
      tck_q <= tck;
    end
  end

  always @* begin
    case (st_q)
      S_TLR:   st_d = tms ? S_TLR  : S_RTI;
      S_RTI:   st_d = tms ? S_SDR  : S_RTI;
      S_SDR:   st_d = tms ? S_SIR  : S_CDR;
      S_CDR:   st_d = tms ? S_E1DR : S_SHDR;
      S_SHDR:  st_d = tms ? S_E1DR : S_SHDR;
      S_E1DR:  st_d = tms ? S_UDR  : S_PDR;
      S_PDR:   st_d = tms ? S_E2DR : S_PDR;
      S_E2DR:  st_d = tms ? S_UDR  : S_SHDR;
      S_UDR:   st_d = tms ? S_SDR  : S_RTI;
      S_SIR:   st_d = tms ? S_TLR  : S_CIR;
      S_CIR:   st_d = tms ? S_E1IR : S_SHIR;
      S_SHIR:  st_d = tms ? S_E1IR : S_SHIR;
      S_E1IR:  st_d = tms ? S_UIR  : S_PIR;
      S_PIR:   st_d = tms ? S_E2IR : S_PIR;
      S_E2IR:  st_d = tms ? S_UIR  : S_SHIR;
      S_UIR:   st_d = tms ? S_SDR  : S_RTI;
      default: st_d = S_TLR;
    endcase
  end

  always @(posedge clock) begin
    if (tap_rst) begin
      st_q <= S_TLR;
    end else if (rise) begin
      st_q <= st_d;
    end
  end

  // capture and shift on rising TCK
  always @(posedge clock) begin
    if (tap_rst) begin
      ir_sh_q  <= `BSCN_IR_CAP;
      byp_q    <= 1'b0;
      id_sh_q  <= {`BSCN_ID_W{1'b0}};
      bsr_sh_q <= {2*N{1'b0}};
    end else if (rise) begin
      if (st_q == S_CIR) begin
        ir_sh_q <= `BSCN_IR_CAP;
      end else if (st_q == S_SHIR) begin
        ir_sh_q <= {tdi, ir_sh_q[`BSCN_IR_W-1:1]};
      end
      if (st_q == S_CDR) begin
        byp_q    <= 1'b0;
        id_sh_q  <= ID_CODE;
        bsr_sh_q <= {core_dout, pad_lvl};
      end else if (st_q == S_SHDR) begin
        byp_q    <= tdi;
        id_sh_q  <= {tdi, id_sh_q[`BSCN_ID_W-1:1]};
        bsr_sh_q <= {tdi, bsr_sh_q[2*N-1:1]};
      end
    end
  end

  // update and TDO on falling TCK
  always @(posedge clock) begin
    if (tap_rst) begin
      ir_q      <= `BSCN_OP_IDCODE;
      bsr_upd_q <= {2*N{1'b0}};
      tdo_q     <= 1'b0;
      tdo_en_q  <= 1'b0;
    end else if (fall) begin
      if (st_q == S_UIR) begin
        ir_q <= ir_sh_q;
      end
      if ((st_q == S_UDR) && op_bsr) begin
        bsr_upd_q <= bsr_sh_q;
      end
      tdo_en_q <= (st_q == S_SHIR) | (st_q == S_SHDR);
      if (st_q == S_SHIR) begin
        tdo_q <= ir_sh_q[0];
      end else if (st_q == S_SHDR) begin
        tdo_q <= op_id ? id_sh_q[0] : (op_bsr ? bsr_sh_q[0] : byp_q);
      end
    end
  end

  // pin ownership; TDO released when not shifting
  always @(posedge clock) begin
    if (rst) begin
      gpio_out     <= 5'h00;
      gpio_oe_n    <= 5'h1f;
      core_gpio_in <= 5'h00;
      op_halt      <= 1'b0;
    end else if (test_mode) begin
      gpio_out     <= {1'b0, tdo_q, 3'h0};
      gpio_oe_n    <= {1'b1, ~tdo_en_q, 3'h7};
      core_gpio_in <= 5'h00;
      op_halt      <= 1'b1;
    end else begin
      gpio_out     <= core_gpio_out;
      gpio_oe_n    <= core_gpio_oe_n;
      core_gpio_in <= lvl[4:0];
      op_halt      <= 1'b0;
    end
  end

  // pin effect of EXTEST, CLAMP and HIGHZ
  always @(posedge clock) begin
    if (rst) begin
      pad_out  <= {N{1'b0}};
      pad_oe_n <= {N{1'b1}};
      core_din <= {N{1'b0}};
    end else begin
      if (test_mode && (op_ext || op_clamp)) begin
        pad_out  <= bsr_upd_q[2*N-1:N];
        pad_oe_n <= {N{1'b0}};
      end else if (test_mode && op_highz) begin
        pad_out  <= {N{1'b0}};
        pad_oe_n <= {N{1'b1}};
      end else begin
        pad_out  <= core_dout;
        pad_oe_n <= core_doe_n;
      end
      // Core sees preloaded values under EXTEST so it cannot react to test patterns
      core_din <= (test_mode && op_ext) ? bsr_upd_q[N-1:0] : pad_lvl;
    end
  end
endmodule // bscn_tap

// file: sim/bscn_jtag_ctl.sv
// Behavioural boundary-scan controller
`timescale 1ns/1ps
module bscn_jtag_ctl (
  // Test pins
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  initial {tck, tms, tdi, trst_n} = 4'h5;
  task cyc(input logic m, d, output logic o);
    {tck, tms, tdi} = {1'b0, m, d};
    #100 tck = 1'b1;
    // Spoil TDI once the rise is taken so that late sampling shows up
    #50 tdi = ~d;
    // Read late in the high phase: the port's pin filter adds delay
    #50 o = tdo;
  endtask
  task rst_tap;
    logic o;
    trst_n = 1'b0;
    #200 trst_n = 1'b1;
    cyc(1'b0, 1'b0, o);
  endtask
  // Idle to shift, n bits LSB first, update, back to idle
  task sh(input logic ir, input int n, input logic [31:0] v, output logic [31:0] q);
    logic o;
    q = 32'h0;
    cyc(1'b1, 1'b0, o);
    if (ir) cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) cyc(i == n - 1, v[i], q[i]);
    cyc(1'b1, 1'b0, o);
    cyc(1'b0, 1'b0, o);
  endtask
endmodule // bscn_jtag_ctl

// file: sim/bscn_tap_chk.sv
// Pin-level checks on the test port
`timescale 1ns/1ps
module bscn_tap_chk #(
  parameter N = 8
) (
  // Clock, reset, select
  input wire         clock,
  input wire         rst,
  input wire         test_select_n,
  // Watched pins
  input wire [4:0]   gpio_out,
  input wire [4:0]   gpio_oe_n,
  input wire [4:0]   core_gpio_out,
  input wire [4:0]   core_gpio_oe_n,
  input wire [4:0]   core_gpio_in,
  input wire         op_halt,
  input wire [N-1:0] core_dout,
  input wire [N-1:0] core_doe_n,
  input wire [N-1:0] pad_out,
  input wire [N-1:0] pad_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  chk_halt_on: assert property (!test_select_n [*8] |=> op_halt)
    else $error("no halt");
  chk_halt_off: assert property (test_select_n [*8] |=> !op_halt)
    else $error("halt stuck");
  chk_core_quiet: assert property (!test_select_n [*8] |=> core_gpio_in == 5'h00)
    else $error("core sees pins");
  chk_pins_pass: assert property (test_select_n [*8] |=> gpio_out == $past(core_gpio_out)
    && gpio_oe_n == $past(core_gpio_oe_n)) else $error("gpio lost");
  chk_pins_test: assert property (!test_select_n [*8] |=> (gpio_oe_n & 5'h17) == 5'h17
    && (gpio_out & 5'h17) == 5'h00) else $error("test pin driven");
  chk_tdo_hold: assert property (op_halt && $changed(gpio_out[3]) |=> $stable(gpio_out[3]) [*6])
    else $error("tdo early");
  chk_pad_pass: assert property (test_select_n [*8] |=> pad_out == $past(core_dout)
    && pad_oe_n == $past(core_doe_n)) else $error("pads lost");
  chk_reset_vals: assert property (disable iff (1'b0) rst |=> gpio_oe_n == 5'h1f && !op_halt
    && gpio_out == 5'h00) else $error("bad reset");
  cover property (op_halt ##1 !op_halt);
  cover property (op_halt && $changed(gpio_out[3]));
  cover property (op_halt && !pad_oe_n[0]);
endmodule // bscn_tap_chk
bind bscn_tap bscn_tap_chk #(.N(N)) i_bscn_tap_chk (
  .clock          (clock),
  .rst            (rst),
  .test_select_n  (test_select_n),
  .gpio_out       (gpio_out),
  .gpio_oe_n      (gpio_oe_n),
  .core_gpio_out  (core_gpio_out),
  .core_gpio_oe_n (core_gpio_oe_n),
  .core_gpio_in   (core_gpio_in),
  .op_halt        (op_halt),
  .core_dout      (core_dout),
  .core_doe_n     (core_doe_n),
  .pad_out        (pad_out),
  .pad_oe_n       (pad_oe_n)
);

// file: sim/bscn_tap_test.sv
// Self-checking bench for the test port
`timescale 1ns/1ps
module bscn_tap_test;
  localparam int N = 16;
  // Identification value is arbitrary
  localparam logic [31:0] ID = 32'h2468ace1;
  localparam logic [31:0] P = 32'h9e37c4b1;
  logic clock = 1'b0, rst = 1'b1, test_select_n = 1'b1;
  logic [4:0] pins = 5'h0a, core_gpio_out = 5'h00, core_gpio_oe_n = 5'h1f;
  logic [N-1:0] core_dout = 16'h3c5a, core_doe_n = 16'hffff, pads = 16'ha5c3;
  wire [4:0] gpio_in, gpio_out, gpio_oe_n, core_gpio_in;
  wire [N-1:0] core_din, pad_in, pad_out, pad_oe_n;
  wire op_halt, tck, tms, tdi, trst_n;
  int n_errors = 0, total_checks = 0;
  logic [31:0] q;
  always #12.5 clock = ~clock;
  assign gpio_in = gpio_oe_n & (test_select_n ? pins : {trst_n, ~gpio_out[3], tdi, tms, tck}) | ~gpio_oe_n & gpio_out;
  assign pad_in = pad_oe_n & pads | ~pad_oe_n & pad_out;
  bscn_tap #(
    .N       (N),
    .ID_CODE (ID)
  ) i_bscn_tap (
    .clock          (clock),
    .rst            (rst),
    .gpio_in        (gpio_in),
    .gpio_out       (gpio_out),
    .gpio_oe_n      (gpio_oe_n),
    .test_select_n  (test_select_n),
    .core_gpio_out  (core_gpio_out),
    .core_gpio_oe_n (core_gpio_oe_n),
    .core_gpio_in   (core_gpio_in),
    .op_halt        (op_halt),
    .core_dout      (core_dout),
    .core_doe_n     (core_doe_n),
    .core_din       (core_din),
    .pad_in         (pad_in),
    .pad_out        (pad_out),
    .pad_oe_n       (pad_oe_n)
  );
  bscn_jtag_ctl i_bscn_jtag_ctl (.tdo(gpio_in[3]), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n));
  task chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task final_report;
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task s(input logic ir, input logic [31:0] v);
    i_bscn_jtag_ctl.sh(ir, ir ? 4 : 32, v, q);
  endtask
  task t_normal;
    for (int i = 0; i < 2; i++) begin
      {pins, core_gpio_out, core_gpio_oe_n} = i ? 15'h2a4c : 15'h05b1;
      tick(8);
      chk(gpio_out, core_gpio_out);
      chk(gpio_oe_n, core_gpio_oe_n);
      chk(core_gpio_in, core_gpio_oe_n & pins | ~core_gpio_oe_n & core_gpio_out);
    end
  endtask
  task t_enter;
    test_select_n = 1'b0;
    tick(10);
    chk(op_halt, 1'b1);
    chk(core_gpio_in, 5'h00);
  endtask
  task t_id;
    i_bscn_jtag_ctl.rst_tap;
    s(1'b1, 32'hf);
    chk(q, 32'h1);
    s(1'b0, ~P);
    chk(q, {~P[30:0], 1'b0});
    i_bscn_jtag_ctl.rst_tap;
    s(1'b0, P);
    chk(q, ID);
  endtask
  task t_bsr;
    s(1'b1, 32'h2);
    s(1'b0, P);
    chk(q, {core_dout, pads});
    s(1'b1, 32'h3);
    s(1'b0, P);
    s(1'b1, 32'h0);
    chk({pad_out, core_din}, P);
    chk(pad_oe_n, 16'h0000);
    s(1'b1, 32'h4);
    chk(pad_oe_n, 16'hffff);
    s(1'b1, 32'h5);
    chk({pad_out, pad_oe_n}, {P[31:16], 16'h0000});
  endtask
  task t_exit;
    {test_select_n, rst} = 2'b11;
    tick(2);
    rst = 1'b0;
    tick(10);
    chk(op_halt, 1'b0);
    chk(gpio_out, core_gpio_out);
  endtask
  initial begin
    tick(16);
    rst = 1'b0;
    tick(4);
    t_normal;
    t_enter;
    t_id;
    t_bsr;
    t_exit;
    final_report;
  end
  initial begin
    #2000000;
    n_errors++;
    final_report;
  end
endmodule // bscn_tap_test
